/* serial_packing_disconnect_control.sv */
// module: packing, flush and disconnect control for one serial channel
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module serial_packing_disconnect_control #(
   parameter logic [27:0] SEC_CYCLES = 28'(spdc_pkg::SEC_CYC),
   parameter logic [27:0] PI0 = spdc_pkg::PI0_CYC,
   parameter logic [27:0] PI1 = spdc_pkg::PI1_CYC,
   parameter logic [27:0] PI2 = spdc_pkg::PI2_CYC,
   parameter logic [27:0] PI3 = spdc_pkg::PI3_CYC
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   // register port
   input wire spdc_pkg::reg_req_t regReq,
   output logic [15:0] regRdata,
   // serial side character stream
   input wire spdc_pkg::char_t serChar,
   // connection events from the network stack, and the hold line pin
   input wire logic connUp,
   input wire logic connOutbound,
   input wire logic connDown,
   input wire logic lineHoldPin,
   // segment control
   output logic sendSegment,
   output logic flushS2n,
   output logic flushN2s,
   output logic dropConn,
   output logic hardClose,
   // option, port and status led outputs
   output logic sendEscape,
   output logic ringShowIp,
   output logic telnetCtrl,
   output logic needPassword,
   output logic stateLed,
   output logic [15:0] listenPort1,
   output logic [15:0] listenPort2,
   output logic [15:0] srcPort
);
   import spdc_pkg::*;

   // ------------------------------------------
   // registers
   // ------------------------------------------
   logic [7:0] discPol, next_discPol;
   logic [7:0] flushPol, next_flushPol;
   logic [7:0] packCtl, next_packCtl;
   logic [7:0] opts, next_opts;
   logic [12:0] idleSec, next_idleSec;
   logic [15:0] trigChars, next_trigChars;
   logic [15:0] port1, next_port1;
   logic [15:0] port2, next_port2;
   logic [15:0] srcBase, next_srcBase;
   logic [15:0] next_regRdata;
   logic connected;

   always_comb begin
      next_discPol = discPol;
      next_flushPol = flushPol;
      next_packCtl = packCtl;
      next_opts = opts;
      next_idleSec = idleSec;
      next_trigChars = trigChars;
      next_port1 = port1;
      next_port2 = port2;
      next_srcBase = srcBase;
      next_regRdata = 16'h0000;
      if (regReq.wr) begin
         unique case (regReq.addr)
            ADDR_DISC: next_discPol = regReq.wdata[7:0];
            ADDR_FLUSH: next_flushPol = regReq.wdata[7:0];
            ADDR_PACK: next_packCtl = regReq.wdata[7:0];
            ADDR_OPTS: next_opts = regReq.wdata[7:0];
            ADDR_IDLE: begin
               // written values 6000 to 8191 saturate; bits 15:13 are dropped
               if (regReq.wdata[12:0] > IDLE_MAX) begin
                  next_idleSec = IDLE_MAX;
               end else begin
                  next_idleSec = regReq.wdata[12:0];
               end
            end
            ADDR_TRIG: next_trigChars = regReq.wdata;
            ADDR_PORT1: next_port1 = regReq.wdata;
            ADDR_PORT2: next_port2 = regReq.wdata;
            ADDR_SRCPORT: next_srcBase = regReq.wdata;
            default: ;
         endcase
      end
      if (regReq.rd) begin
         unique case (regReq.addr)
            ADDR_DISC: next_regRdata = {8'h00, discPol};
            ADDR_FLUSH: next_regRdata = {8'h00, flushPol};
            ADDR_PACK: next_regRdata = {8'h00, packCtl};
            ADDR_OPTS: next_regRdata = {8'h00, opts};
            ADDR_IDLE: next_regRdata = {3'h0, idleSec};
            ADDR_TRIG: next_regRdata = trigChars;
            ADDR_PORT1: next_regRdata = port1;
            ADDR_PORT2: next_regRdata = port2;
            ADDR_SRCPORT: next_regRdata = srcPort;
            ADDR_STATUS: next_regRdata = {15'h0000, connected};
            default: next_regRdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         discPol <= DISC_RST;
         flushPol <= FLUSH_RST;
         packCtl <= PACK_RST;
         opts <= OPTS_RST;
         idleSec <= 13'h0000;
         trigChars <= 16'h0000;
         port1 <= PORT1_RST;
         port2 <= PORT2_RST;
         srcBase <= 16'h0000;
         regRdata <= 16'h0000;
      end else if (clkEn) begin
         discPol <= next_discPol;
         flushPol <= next_flushPol;
         packCtl <= next_packCtl;
         opts <= next_opts;
         idleSec <= next_idleSec;
         trigChars <= next_trigChars;
         port1 <= next_port1;
         port2 <= next_port2;
         srcBase <= next_srcBase;
         regRdata <= next_regRdata;
      end
   end

   // ------------------------------------------
   // hold line synchroniser and edge
   // ------------------------------------------
   logic [2:0] holdSync, next_holdSync;
   logic holdState, next_holdState;
   logic holdFall;
   always_comb begin
      next_holdSync = {holdSync[1:0], lineHoldPin};
      next_holdState = holdState;
      if (holdSync[1] == holdSync[2]) begin
         next_holdState = holdSync[2];
      end
   end
   assign holdFall = holdState & ~next_holdState;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         holdSync <= 3'h7;
         holdState <= 1'b1;
      end else if (clkEn) begin
         holdSync <= next_holdSync;
         holdState <= next_holdState;
      end
   end

   // ------------------------------------------
   // connection state, source port, idle timer
   // ------------------------------------------
   logic next_connected;
   logic [15:0] srcOffs, next_srcOffs;
   logic [27:0] secCnt, next_secCnt;
   logic [12:0] idleCnt, next_idleCnt;
   logic eotHit, idleHit, holdHit;
   logic next_drop, dropReg;

   // events from the stream side: EOT only on serial input
   assign eotHit = connected & serChar.valid & discPol[DP_EOT] &
      discPol[DP_TELNET] & (serChar.data == EOT_CHAR);
   assign holdHit = connected & discPol[DP_HOLD] & holdFall;
   assign idleHit = connected & (idleSec != 13'h0000) &
      (idleCnt >= idleSec);

   always_comb begin
      next_connected = connected;
      next_srcOffs = srcOffs;
      next_secCnt = secCnt;
      next_idleCnt = idleCnt;
      // one pulse per drop although a detect stands until connected clears
      next_drop = (eotHit | holdHit | idleHit) & ~dropReg;
      if (connUp & ~connected) begin
         next_connected = 1'b1;
         if (connOutbound & opts[OP_AUTOINC]) begin
            next_srcOffs = srcOffs + 16'h0001;
         end
      end
      if (connDown | dropReg) begin
         next_connected = 1'b0;
      end
      // serial activity restarts the inactivity count
      if (~connected | serChar.valid) begin
         next_secCnt = 28'h0000000;
         next_idleCnt = 13'h0000;
      end else if (secCnt >= SEC_CYCLES - 28'h0000001) begin
         next_secCnt = 28'h0000000;
         if (idleCnt != IDLE_MAX) begin
            next_idleCnt = idleCnt + 13'h0001;
         end
      end else begin
         next_secCnt = secCnt + 28'h0000001;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         connected <= 1'b0;
         srcOffs <= 16'h0000;
         secCnt <= 28'h0000000;
         idleCnt <= 13'h0000;
         dropReg <= 1'b0;
      end else if (clkEn) begin
         connected <= next_connected;
         srcOffs <= next_srcOffs;
         secCnt <= next_secCnt;
         idleCnt <= next_idleCnt;
         dropReg <= next_drop;
      end
   end

   // ------------------------------------------
   // flush pulses, drop pulses, led and option outputs
   // ------------------------------------------
   logic next_flushS2n, next_flushN2s;
   logic upEvt, downEvt;
   assign upEvt = connUp & ~connected;
   assign downEvt = connected & (connDown | dropReg);
   always_comb begin
      next_flushS2n = (upEvt & connOutbound & flushPol[FL_S2N_OUT]) |
         (upEvt & ~connOutbound & flushPol[FL_S2N_IN]) |
         (downEvt & flushPol[FL_S2N_DISC]);
      next_flushN2s = (upEvt & connOutbound & flushPol[FL_N2S_OUT]) |
         (upEvt & ~connOutbound & flushPol[FL_N2S_IN]) |
         (downEvt & flushPol[FL_N2S_DISC]);
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flushS2n <= 1'b0;
         flushN2s <= 1'b0;
      end else if (clkEn) begin
         flushS2n <= next_flushS2n;
         flushN2s <= next_flushN2s;
      end
   end

   assign dropConn = dropReg;
   assign hardClose = dropReg & ~discPol[DP_NOHARD];
   assign sendEscape = opts[OP_ESC];
   assign ringShowIp = opts[OP_RINGIP];
   assign telnetCtrl = discPol[DP_TELNET];
   assign needPassword = discPol[DP_PASSWD];
   // led blinks at one hertz from the second counter; serial traffic
   // restarts that count, so a busy line holds the led dark
   assign stateLed = connected ? (~discPol[DP_LEDOFF] &
      (secCnt >= (SEC_CYCLES >> 1))) : 1'b1;
   assign listenPort1 = port1;
   assign listenPort2 = port2;
   assign srcPort = srcBase + srcOffs;

   // ------------------------------------------
   // packing engine
   // ------------------------------------------
   pack_state_t pState, next_pState;
   logic [27:0] pTimer, next_pTimer;
   logic [1:0] trailLeft, next_trailLeft;
   logic [7:0] lastChar, next_lastChar;
   logic next_sendSegment;
   logic trigEn, trigMatch, trigHit, altPack, pExpire;
   logic [27:0] pLimit;

   function automatic logic [27:0] interval(input logic [1:0] sel);
      unique case (sel)
         2'h0: interval = PI0;
         2'h1: interval = PI1;
         2'h2: interval = PI2;
         2'h3: interval = PI3;
      endcase
   endfunction

   assign altPack = flushPol[FL_ALTPACK];
   // standard packing uses the shortest interval and no triggers
   assign pLimit = altPack ? interval(packCtl[1:0]) : PI0;
   assign trigEn = altPack & (trigChars[7:0] != TRIG_OFF);
   always_comb begin
      if (packCtl[PK_SEQ]) begin
         trigMatch = (lastChar == trigChars[7:0]) &
            (serChar.data == trigChars[15:8]);
      end else begin
         trigMatch = (serChar.data == trigChars[7:0]) |
            (serChar.data == trigChars[15:8]);
      end
   end
   assign pExpire = (pTimer >= pLimit - 28'h0000001);
   assign trigHit = serChar.valid & trigEn & trigMatch;

   always_comb begin
      next_pState = pState;
      next_pTimer = pTimer;
      next_trailLeft = trailLeft;
      next_lastChar = lastChar;
      next_sendSegment = 1'b0;
      if (serChar.valid) begin
         next_lastChar = serChar.data;
      end
      unique case (pState)
         // a trigger in idle or fill sends at once when no trailing characters are set
         PK_IDLE, PK_FILL: begin
            if (trigHit) begin
               next_pTimer = 28'h0000000;
               if (packCtl[3:2] == TRAIL_NONE) begin
                  next_sendSegment = 1'b1;
                  next_pState = PK_IDLE;
               end else begin
                  next_trailLeft = packCtl[3:2];
                  next_pState = PK_TRAIL;
               end
            end else if (pState == PK_IDLE) begin
               next_pTimer = 28'h0000000;
               if (serChar.valid) begin
                  next_pState = PK_FILL;
               end
            end else if (serChar.valid & ~packCtl[PK_IMMED]) begin
               next_pTimer = 28'h0000000;
            end else if (pExpire) begin
               next_sendSegment = 1'b1;
               next_pState = PK_IDLE;
            end else begin
               next_pTimer = pTimer + 28'h0000001;
            end
         end
         PK_TRAIL: begin
            if (serChar.valid) begin
               next_trailLeft = trailLeft - 2'h1;
               if (trailLeft == 2'h1) begin
                  next_sendSegment = 1'b1;
                  next_pState = PK_IDLE;
               end
            end else if (pExpire) begin
               next_sendSegment = 1'b1;
               next_pState = PK_IDLE;
            end else begin
               next_pTimer = pTimer + 28'h0000001;
            end
         end
         default: next_pState = PK_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pState <= PK_IDLE;
         pTimer <= 28'h0000000;
         trailLeft <= 2'h0;
         lastChar <= 8'h00;
         sendSegment <= 1'b0;
      end else if (clkEn) begin
         pState <= next_pState;
         pTimer <= next_pTimer;
         trailLeft <= next_trailLeft;
         lastChar <= next_lastChar;
         sendSegment <= next_sendSegment;
      end
   end

   // ------------------------------------------
   // assertions
   // ------------------------------------------
   property p_eot;
      @(posedge ref_clk) disable iff (rst)
      (clkEn & eotHit & ~dropConn) |=> dropConn;
   endproperty
   a_eot: assert property (p_eot) else $error("eot not dropped");
   property p_hold;
      @(posedge ref_clk) disable iff (rst)
      (clkEn & holdFall & connected & discPol[DP_HOLD] & ~dropConn) |=>
         dropConn;
   endproperty
   a_hold: assert property (p_hold) else $error("hold fall");
   property p_holdign;
      @(posedge ref_clk) disable iff (rst)
      (clkEn & ~discPol[DP_HOLD] & ~eotHit & ~idleHit) |=> ~dropConn;
   endproperty
   a_holdign: assert property (p_holdign) else $error("spurious");
   property p_hard;
      @(posedge ref_clk) disable iff (rst)
      hardClose |-> (dropConn & ~discPol[DP_NOHARD]);
   endproperty
   a_hard: assert property (p_hard) else $error("hard close");
   property p_led;
      @(posedge ref_clk) disable iff (rst)
      (connected & discPol[DP_LEDOFF]) |-> ~stateLed;
   endproperty
   a_led: assert property (p_led) else $error("led on");
   property p_flush;
      @(posedge ref_clk) disable iff (rst)
      (clkEn & downEvt & flushPol[FL_S2N_DISC]) |=> flushS2n;
   endproperty
   a_flush: assert property (p_flush) else $error("no flush");
   property p_flushn;
      @(posedge ref_clk) disable iff (rst)
      (clkEn & upEvt & connOutbound & flushPol[FL_N2S_OUT]) |=> flushN2s;
   endproperty
   a_flushn: assert property (p_flushn) else $error("no flush");
   property p_trig;
      @(posedge ref_clk) disable iff (rst)
      (clkEn & pState != PK_TRAIL & serChar.valid & trigEn & trigMatch &
       packCtl[3:2] == TRAIL_NONE) |=> sendSegment;
   endproperty
   a_trig: assert property (p_trig) else $error("no send");
   property p_notrig;
      @(posedge ref_clk) disable iff (rst)
      (clkEn & trigChars[7:0] == TRIG_OFF & pState != PK_TRAIL &
       serChar.valid & ~packCtl[PK_IMMED]) |=> ~sendSegment;
   endproperty
   a_notrig: assert property (p_notrig) else $error("trig on");
   property p_idle;
      @(posedge ref_clk) disable iff (rst)
      (clkEn & idleHit & ~dropConn) |=> dropConn;
   endproperty
   a_idle: assert property (p_idle) else $error("idle drop");
   c_send: cover property (@(posedge ref_clk) sendSegment);
   c_drop: cover property (@(posedge ref_clk) dropConn);
   c_trail: cover property (@(posedge ref_clk) pState == PK_TRAIL);
endmodule
`default_nettype wire

/* spdc_pkg.sv */
// package: register map, field positions and timing constants
//
// Function
// - option to emit escape sequence, default on
// - option to append caller address to ring
// - source port auto increment, default off
// - policy bit 7: hold line fall drops
// - policy bit 6: com control, terminal type
// - policy bit 4: demand password on inbound
// - policy bit 3 clear: hard disconnect allowed
// - policy bit 0: LED off while connected
// - bits 5 and 6: serial 04 drops
// - flush bits 4-6 clear serial-to-net buffer
// - flush bits 0-2 clear net-to-serial buffer
// - flush bit 7 selects alternate packing
// - pack bits 1:0 select packing interval
// - pack bits 3:2 trailing character count
// - pack bit 4: triggers as two-byte sequence
// - pack bit 5: later characters do not restart the packing timer
// - idle timeout drops connection, zero disables
// - trigger character sends with waiting data
// - first trigger zero disables recognition
// - listening ports default 10001 and 10002
// - verbose ring carries remote address
package spdc_pkg;
   // -----------------------------------------
   // register offsets
   // -----------------------------------------
   localparam logic [3:0] ADDR_DISC = 4'h0;
   localparam logic [3:0] ADDR_FLUSH = 4'h1;
   localparam logic [3:0] ADDR_PACK = 4'h2;
   localparam logic [3:0] ADDR_OPTS = 4'h3;
   localparam logic [3:0] ADDR_IDLE = 4'h4;
   localparam logic [3:0] ADDR_TRIG = 4'h5;
   localparam logic [3:0] ADDR_PORT1 = 4'h6;
   localparam logic [3:0] ADDR_PORT2 = 4'h7;
   localparam logic [3:0] ADDR_SRCPORT = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'h9;
   // -----------------------------------------
   // field positions and reset values
   // -----------------------------------------
   localparam int DP_HOLD = 7;
   localparam int DP_TELNET = 6;
   localparam int DP_EOT = 5;
   localparam int DP_PASSWD = 4;
   localparam int DP_NOHARD = 3;
   localparam int DP_LEDOFF = 0;
   localparam int FL_S2N_OUT = 4;
   localparam int FL_S2N_IN = 5;
   localparam int FL_S2N_DISC = 6;
   localparam int FL_N2S_OUT = 0;
   localparam int FL_N2S_IN = 1;
   localparam int FL_N2S_DISC = 2;
   localparam int FL_ALTPACK = 7;
   localparam int PK_SEQ = 4;
   localparam int PK_IMMED = 5;
   localparam int OP_ESC = 0;
   localparam int OP_RINGIP = 1;
   localparam int OP_AUTOINC = 2;
   localparam logic [7:0] DISC_RST = 8'h00;
   localparam logic [7:0] FLUSH_RST = 8'h00;
   localparam logic [7:0] PACK_RST = 8'h00;
   localparam logic [7:0] OPTS_RST = 8'h03;
   localparam logic [7:0] EOT_CHAR = 8'h04;
   localparam logic [7:0] TRIG_OFF = 8'h00;
   localparam logic [15:0] PORT1_RST = 16'd10001;
   localparam logic [15:0] PORT2_RST = 16'd10002;
   localparam logic [12:0] IDLE_MAX = 13'd5999;
   localparam logic [1:0] TRAIL_NONE = 2'h0;
   // -----------------------------------------
   // timing
   // -----------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int PI0_MS = 12;
   localparam int PI1_MS = 52;
   localparam int PI2_MS = 250;
   localparam int PI3_MS = 5000;
   localparam int SEC_CYC = CLK_HZ;
   localparam logic [27:0] PI0_CYC = 28'(PI0_MS * (CLK_HZ / 1000));
   localparam logic [27:0] PI1_CYC = 28'(PI1_MS * (CLK_HZ / 1000));
   localparam logic [27:0] PI2_CYC = 28'(PI2_MS * (CLK_HZ / 1000));
   localparam logic [27:0] PI3_CYC = 28'(PI3_MS * (CLK_HZ / 1000));
   // -----------------------------------------
   // carriers
   // -----------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } reg_req_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } char_t;
   typedef enum logic [2:0] {
      PK_IDLE = 3'b001,
      PK_FILL = 3'b010,
      PK_TRAIL = 3'b100
   } pack_state_t;
endpackage

/* far_end.sv */
// far-side model: attached serial device and network stack events
`timescale 1ns/1ps
`default_nettype none
module far_end (
   // clock
   input wire logic ref_clk,
   // serial stream and link events
   output var spdc_pkg::char_t serChar,
   output logic connUp,
   output logic connOutbound,
   output logic connDown,
   output logic lineHoldPin
);
   import spdc_pkg::*;
   initial begin
      serChar = '{valid: 1'b0, data: 8'hA5};
      connUp = 1'b0;
      connOutbound = 1'b0;
      connDown = 1'b0;
      lineHoldPin = 1'b1;
   end
   // idle data shows the inverse so a stale byte never looks fresh;
   // no plus run is ever sent, so guard silence holds
   task automatic sendChar(input logic [7:0] d, input int gap);
      @(posedge ref_clk);
      serChar <= '{valid: 1'b1, data: d};
      @(posedge ref_clk);
      serChar <= '{valid: 1'b0, data: ~d};
      repeat (gap) @(posedge ref_clk);
   endtask
   task automatic connect(input logic ob);
      @(posedge ref_clk);
      connUp <= 1'b1;
      connOutbound <= ob;
      @(posedge ref_clk);
      connUp <= 1'b0;
      connOutbound <= ~ob;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic disconnect();
      @(posedge ref_clk);
      connDown <= 1'b1;
      @(posedge ref_clk);
      connDown <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic setHold(input logic v);
      @(posedge ref_clk);
      lineHoldPin <= v;
   endtask
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking testbench for packing and disconnect control
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import spdc_pkg::*;
   // ----------------------------------------
   // design, far end and counters
   // ----------------------------------------
   localparam int SECC = 100;
   localparam int PIV [4] = '{10, 20, 30, 40};
   localparam logic [7:0] DR_DISC [7] = '{8'h60, 8'h20, 8'h68, 8'h80,
      8'h00, 8'h00, 8'h00};
   localparam logic [1:0] DR_ACT [7] = '{0, 0, 0, 1, 1, 2, 2};
   localparam logic [1:0] DR_EXP [7] = '{3, 0, 2, 3, 0, 3, 0};
   localparam logic [7:0] TG_PACK [7] = '{8'h03, 8'h07, 8'h07, 8'h03,
      8'h13, 8'h13, 8'h03};
   localparam logic [15:0] TG_TRIG [7] = '{16'h000D, 16'h000D, 16'h000D,
      16'h0A00, 16'h0A0D, 16'h0A0D, 16'h0A0D};
   localparam logic [15:0] TG_CH [7] = '{16'h000D, 16'h000D, 16'h0D55,
      16'h000A, 16'h000A, 16'h0D0A, 16'h000A};
   localparam logic [6:0] TG_EXP = 7'b1100101;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   reg_req_t regReq = '0;
   logic [15:0] regRdata, listenPort1, listenPort2, srcPort;
   char_t serChar;
   logic connUp, connOutbound, connDown, lineHoldPin;
   logic sendSegment, flushS2n, flushN2s, dropConn, hardClose;
   logic sendEscape, ringShowIp, telnetCtrl, needPassword, stateLed;
   int errors = 0;
   int tests_run = 0;
   int nSeg, nS2n, nN2s, nDrop, nHard;
   always #20 ref_clk = ~ref_clk;
   serial_packing_disconnect_control #(.SEC_CYCLES(28'(SECC)),
      .PI0(28'(PIV[0])), .PI1(28'(PIV[1])), .PI2(28'(PIV[2])),
      .PI3(28'(PIV[3]))) serial_packing_disconnect_control_inst (
      .ref_clk, .rst, .clkEn, .regReq, .regRdata, .serChar,
      .connUp, .connOutbound, .connDown, .lineHoldPin, .sendSegment,
      .flushS2n, .flushN2s, .dropConn, .hardClose, .sendEscape,
      .ringShowIp, .telnetCtrl, .needPassword, .stateLed, .listenPort1,
      .listenPort2, .srcPort);
   far_end far_end_inst (.ref_clk, .serChar, .connUp, .connOutbound,
      .connDown, .lineHoldPin);
   always @(posedge ref_clk) begin
      nSeg += int'(sendSegment === 1'b1);
      nS2n += int'(flushS2n === 1'b1);
      nN2s += int'(flushN2s === 1'b1);
      nDrop += int'(dropConn === 1'b1);
      nHard += int'(hardClose === 1'b1);
   end
   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic clr();
      #1 {nSeg, nS2n, nN2s, nDrop, nHard} = '0;
   endtask
   task automatic check(input string w, input logic [15:0] e,
      input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic chkBit(input string w, input logic e, input logic g);
      check(w, {15'h0000, e}, {15'h0000, g});
   endtask
   task automatic regWr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      regReq <= '0;
      #1;
   endtask
   task automatic rdCheck(input string w, input logic [3:0] a,
      input logic [15:0] e);
      @(posedge ref_clk);
      regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge ref_clk);
      regReq <= '0;
      #1 check(w, e, regRdata);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic testRegs();
      chkBit("esc", 1'b1, sendEscape);
      chkBit("ring", 1'b1, ringShowIp);
      chkBit("led", 1'b1, stateLed);
      check("port1", PORT1_RST, listenPort1);
      check("port2", PORT2_RST, listenPort2);
      rdCheck("disc", ADDR_DISC, {8'h00, DISC_RST});
      rdCheck("flush", ADDR_FLUSH, {8'h00, FLUSH_RST});
      rdCheck("pack", ADDR_PACK, {8'h00, PACK_RST});
      rdCheck("opts", ADDR_OPTS, {8'h00, OPTS_RST});
      regWr(4'hF, 16'h00FF);
      rdCheck("unmapped", 4'hF, 16'h0000);
      regWr(ADDR_IDLE, 16'd6000);
      rdCheck("idle", ADDR_IDLE, {3'h0, IDLE_MAX});
      regWr(ADDR_PORT1, 16'h1234);
      check("port1 wr", 16'h1234, listenPort1);
      @(posedge ref_clk) clkEn <= 1'b0;
      regWr(ADDR_PORT2, 16'h4321);
      check("port2 frozen", PORT2_RST, listenPort2);
      @(posedge ref_clk) clkEn <= 1'b1;
      regWr(ADDR_PORT2, 16'h4321);
      check("port2 wr", 16'h4321, listenPort2);
      regWr(ADDR_OPTS, 16'h0000);
      chkBit("esc off", 1'b0, sendEscape);
      chkBit("ring off", 1'b0, ringShowIp);
      regWr(ADDR_DISC, 16'h0050);
      chkBit("telnet", 1'b1, telnetCtrl);
      chkBit("passwd", 1'b1, needPassword);
      regWr(ADDR_DISC, 16'h0000);
      chkBit("telnet off", 1'b0, telnetCtrl);
      chkBit("passwd off", 1'b0, needPassword);
   endtask
   task automatic testConn();
      int ones;
      for (int k = 0; k < 3; k++) begin
         regWr(ADDR_FLUSH, 16'h0011 << k);
         clr();
         far_end_inst.connect(k == 0);
         far_end_inst.disconnect();
         check("s2n", 16'h0001, 16'(nS2n));
         check("n2s", 16'h0001, 16'(nN2s));
      end
      regWr(ADDR_SRCPORT, 16'h2000);
      regWr(ADDR_OPTS, 16'h0007);
      repeat (2) far_end_inst.connect(1'b1);
      check("src", 16'h2001, srcPort);
      ones = 0;
      repeat (SECC + 10) @(posedge ref_clk) ones += int'(stateLed === 1'b1);
      chkBit("led blink", 1'b1, ones > 0 && ones < SECC + 10);
      far_end_inst.disconnect();
      regWr(ADDR_DISC, 16'h0001);
      far_end_inst.connect(1'b1);
      rdCheck("src rd", ADDR_SRCPORT, 16'h2002);
      rdCheck("status", ADDR_STATUS, 16'h0001);
      ones = 0;
      repeat (50) @(posedge ref_clk) ones += int'(stateLed !== 1'b0);
      check("led conn", 16'h0000, 16'(ones));
      far_end_inst.disconnect();
      regWr(ADDR_OPTS, 16'h0003);
   endtask
   task automatic testDrop();
      for (int i = 0; i < 7; i++) begin
         regWr(ADDR_DISC, {8'h00, DR_DISC[i]});
         regWr(ADDR_IDLE, (i == 5) ? 16'h0001 : 16'h0000);
         far_end_inst.connect(1'b0);
         clr();
         if (DR_ACT[i] == 2'd0)
            far_end_inst.sendChar(EOT_CHAR, 0);
         if (DR_ACT[i] == 2'd1)
            far_end_inst.setHold(1'b0);
         repeat (SECC + 30) @(posedge ref_clk);
         check("drop", 16'(DR_EXP[i][1]), 16'(nDrop));
         check("hard", 16'(DR_EXP[i][0]), 16'(nHard));
         if (nDrop == 0)
            far_end_inst.disconnect();
         far_end_inst.setHold(1'b1);
      end
      regWr(ADDR_DISC, 16'h0000);
      regWr(ADDR_IDLE, 16'h0000);
   endtask
   // cycles from a lone character to the segment it starts
   task automatic measure(input int e);
      int n;
      far_end_inst.sendChar(8'h41, 0);
      n = 0;
      #1;
      while (sendSegment !== 1'b1 && n < 300) begin
         @(posedge ref_clk);
         #1 n++;
      end
      chkBit("interval", 1'b1, n >= e - 2 && n <= e + 2);
   endtask
   task automatic testPack();
      far_end_inst.connect(1'b1);
      regWr(ADDR_FLUSH, 16'h0080);
      for (int k = 0; k < 4; k++) begin
         regWr(ADDR_PACK, 16'(k));
         measure(PIV[k]);
      end
      for (int m = 0; m < 2; m++) begin
         regWr(ADDR_PACK, (m == 1) ? 16'h0021 : 16'h0001);
         clr();
         repeat (4) far_end_inst.sendChar(8'h42, 4);
         repeat (4) @(posedge ref_clk);
         #1 check("early", 16'(m), 16'(nSeg));
         repeat (60) @(posedge ref_clk);
      end
      for (int i = 0; i < 7; i++) begin
         regWr(ADDR_PACK, {8'h00, TG_PACK[i]});
         regWr(ADDR_TRIG, TG_TRIG[i]);
         clr();
         if (TG_CH[i][15:8] != 8'h00)
            far_end_inst.sendChar(TG_CH[i][15:8], 2);
         far_end_inst.sendChar(TG_CH[i][7:0], 3);
         #1 check("trig", 16'(TG_EXP[i]), 16'(nSeg));
         repeat (60) @(posedge ref_clk);
      end
      regWr(ADDR_FLUSH, 16'h0000);
      measure(PIV[0]);
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      testRegs();
      testConn();
      testDrop();
      testPack();
      complete_run();
   end
   // the whole sequence needs about 2100 cycles
   initial begin
      #(40 * 20000);
      errors++;
      complete_run();
   end
endmodule
`default_nettype wire
